// File: cmp_pkg.sv
package cmp_pkg;
   // Channel count
   localparam int NUM_CH = 2;
   // Register byte addresses
   localparam logic [11:0] OFF_CTRL1 = 12'h000;
   localparam logic [11:0] OFF_CTRL2 = 12'h004;
   localparam logic [11:0] OFF_STAT = 12'h008;
   localparam logic [11:0] OFF_IRQ_STAT = 12'h00C;
   localparam logic [11:0] OFF_IRQ_MASK = 12'h010;
   // Control register field positions
   localparam int CTL_ON = 15;
   localparam int CTL_OE = 14;
   localparam int CTL_INV = 13;
   localparam int CTL_LP = 12;
   localparam int CTL_EVT = 9;
   localparam int CTL_RES = 8;
   localparam int CTL_EDGE_HI = 7;
   localparam int CTL_EDGE_LO = 6;
   localparam int CTL_NONINV = 4;
   localparam int CTL_INVSEL_HI = 1;
   localparam int CTL_INVSEL_LO = 0;
   // Status register field positions
   localparam int ST_IDLE = 15;
   localparam int ST_EVT2 = 9;
   localparam int ST_EVT1 = 8;
   localparam int ST_RES2 = 1;
   localparam int ST_RES1 = 0;
   // Reset values
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [15:0] STAT_RST = 16'h0000;
   // Writable bits of a control register (event flag handled apart)
   localparam logic [15:0] CTRL_WMASK = 16'hF0D3;
   // Event selection codes
   typedef enum logic [1:0] {
      EV_NONE = 2'b00,
      EV_RISE = 2'b01,
      EV_FALL = 2'b10,
      EV_ANY = 2'b11
   } edge_sel_t;
   // Per-channel analog controls
   typedef struct packed {
      logic enable;
      logic low_power;
      logic noninv_sel;
      logic [1:0] inv_sel;
   } analog_ctl_t;
endpackage : cmp_pkg

// File: dual_comparator_control.sv
`timescale 1ns/1ps
`default_nettype none
module dual_comparator_control (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Device power state
   input wire logic cpu_idle,
   // Analog cores
   input wire logic [1:0] raw_result,
   output cmp_pkg::analog_ctl_t analog_ctl [2],
   // Output pins
   output logic [1:0] result_pin,
   output logic [1:0] result_pin_oe,
   // Interrupt
   output logic irq
);
   import cmp_pkg::*;

   logic [15:0] ctrl_q [2];
   logic [15:0] ctrl_d [2];
   logic idle_q, idle_d;
   logic [1:0] evt_q, evt_d;
   logic [1:0] ist_q, ist_d;
   logic [1:0] imask_q, imask_d;
   logic [2:0] sync_q [2];
   logic [2:0] sync_d [2];
   logic [1:0] clean_q, clean_d;
   logic [1:0] adj_prev_q, adj_prev_d;
   logic wr_pend_q, wr_pend_d;
   logic [11:0] wr_addr_q, wr_addr_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] active;
   logic [1:0] adj;
   logic [1:0] hit;
   logic [15:0] stat_word;
   logic take;

   // Channel is live when enabled and not held off by idle stop
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         active[i] = ctrl_q[i][CTL_ON] & ~(idle_q & cpu_idle);
         analog_ctl[i].enable = active[i];
         analog_ctl[i].low_power = ctrl_q[i][CTL_LP];
         analog_ctl[i].noninv_sel = ctrl_q[i][CTL_NONINV];
         analog_ctl[i].inv_sel = ctrl_q[i][CTL_INVSEL_HI:CTL_INVSEL_LO];
         // Pin sees the raw core output, so its timing is not clock bound
         result_pin[i] = active[i] & (raw_result[i] ^ ctrl_q[i][CTL_INV]);
         result_pin_oe[i] = active[i] & ctrl_q[i][CTL_OE];
      end
   end

   // Three-stage sampling; the filtered level moves when stages two and three agree
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         sync_d[i] = {sync_q[i][1:0], raw_result[i]};
         clean_d[i] = (sync_q[i][2] == sync_q[i][1]) ? sync_q[i][2] : clean_q[i];
      end
   end

   // Polarity-adjusted result, forced low while the channel is off
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         adj[i] = active[i] & (clean_q[i] ^ ctrl_q[i][CTL_INV]);
      end
   end

   // Edge detection on the adjusted result, per selected code
   always_comb begin
      for (int i = 0; i < NUM_CH; i++) begin
         adj_prev_d[i] = adj[i];
         case (edge_sel_t'(ctrl_q[i][CTL_EDGE_HI:CTL_EDGE_LO]))
            EV_ANY: hit[i] = adj[i] ^ adj_prev_q[i];
            EV_FALL: hit[i] = ctrl_q[i][CTL_INV] ? (adj[i] & ~adj_prev_q[i])
                                                : (~adj[i] & adj_prev_q[i]);
            EV_RISE: hit[i] = ctrl_q[i][CTL_INV] ? (~adj[i] & adj_prev_q[i])
                                                : (adj[i] & ~adj_prev_q[i]);
            EV_NONE: hit[i] = 1'b0;
            default: hit[i] = 1'b0;
         endcase
         // A set flag masks further triggers
         hit[i] = hit[i] & active[i] & ~evt_q[i];
      end
   end

   // Bus: address phase taken here, write data lands one cycle later
   assign take = hsel & hready & htrans[1];
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = rdata_q;

   // Shared status word
   always_comb begin
      stat_word = STAT_RST;
      stat_word[ST_IDLE] = idle_q;
      stat_word[ST_EVT2] = evt_q[1];
      stat_word[ST_EVT1] = evt_q[0];
      stat_word[ST_RES2] = adj[1];
      stat_word[ST_RES1] = adj[0];
   end

   // Register next state; hardware set beats software clear
   always_comb begin
      wr_pend_d = take & hwrite;
      wr_addr_d = haddr;
      rdata_d = rdata_q;
      idle_d = idle_q;
      imask_d = imask_q;
      ist_d = ist_q;
      evt_d = evt_q;
      for (int i = 0; i < NUM_CH; i++) begin
         ctrl_d[i] = ctrl_q[i];
      end
      if (wr_pend_q) begin
         case (wr_addr_q)
            OFF_CTRL1: begin
               ctrl_d[0] = hwdata[15:0] & CTRL_WMASK;
               evt_d[0] = hwdata[CTL_EVT];
            end
            OFF_CTRL2: begin
               ctrl_d[1] = hwdata[15:0] & CTRL_WMASK;
               evt_d[1] = hwdata[CTL_EVT];
            end
            OFF_STAT: idle_d = hwdata[ST_IDLE];
            OFF_IRQ_STAT: ist_d = ist_q & ~hwdata[1:0];
            OFF_IRQ_MASK: imask_d = hwdata[1:0];
            default: ;
         endcase
      end
      evt_d = evt_d | hit;
      ist_d = ist_d | hit;
      if (take & ~hwrite) begin
         case (haddr)
            OFF_CTRL1: rdata_d = {16'h0000, ctrl_q[0] | ({15'h0000, evt_q[0]} << CTL_EVT)
                                  | ({15'h0000, adj[0]} << CTL_RES)};
            OFF_CTRL2: rdata_d = {16'h0000, ctrl_q[1] | ({15'h0000, evt_q[1]} << CTL_EVT)
                                  | ({15'h0000, adj[1]} << CTL_RES)};
            OFF_STAT: rdata_d = {16'h0000, stat_word};
            OFF_IRQ_STAT: rdata_d = {30'h0, ist_q};
            OFF_IRQ_MASK: rdata_d = {30'h0, imask_q};
            default: rdata_d = 32'h00000000;
         endcase
      end
   end

   // Registers
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         for (int i = 0; i < NUM_CH; i++) begin
            ctrl_q[i] <= CTRL_RST;
            sync_q[i] <= 3'h0;
         end
         idle_q <= 1'b0;
         evt_q <= 2'h0;
         ist_q <= 2'h0;
         imask_q <= 2'h0;
         clean_q <= 2'h0;
         adj_prev_q <= 2'h0;
         wr_pend_q <= 1'b0;
         wr_addr_q <= 12'h000;
         rdata_q <= 32'h00000000;
      end else begin
         ctrl_q <= ctrl_d;
         sync_q <= sync_d;
         idle_q <= idle_d;
         evt_q <= evt_d;
         ist_q <= ist_d;
         imask_q <= imask_d;
         clean_q <= clean_d;
         adj_prev_q <= adj_prev_d;
         wr_pend_q <= wr_pend_d;
         wr_addr_q <= wr_addr_d;
         rdata_q <= rdata_d;
      end
   end

   // Level interrupt from unmasked sticky bits
   assign irq = |(ist_q & imask_q);

   // Write strobes per control register, decoded once for the checks below
   logic [1:0] wr_ctrl;
   always_comb begin
      wr_ctrl[0] = wr_pend_q & (wr_addr_q == OFF_CTRL1);
      wr_ctrl[1] = wr_pend_q & (wr_addr_q == OFF_CTRL2);
   end

   // Event flags: a selected edge raises the flag at the next edge
   a_flag_sets: assert property (@(posedge sys_clk) disable iff (!nrst)
      hit[0] |=> evt_q[0])
      else $error("event flag not set");
   a_flag_sets_two: assert property (@(posedge sys_clk) disable iff (!nrst)
      hit[1] |=> evt_q[1])
      else $error("event flag two not set");
   // A standing flag blocks every further trigger
   a_flag_blocks: assert property (@(posedge sys_clk) disable iff (!nrst)
      evt_q[1] |-> !hit[1])
      else $error("trigger while flag set");
   a_flag_blocks_one: assert property (@(posedge sys_clk) disable iff (!nrst)
      evt_q[0] |-> !hit[0])
      else $error("trigger while flag one set");
   // Only software takes a flag down; without a write to its register it stays
   a_flag_sticky: assert property (@(posedge sys_clk) disable iff (!nrst)
      (evt_q[0] && !wr_ctrl[0]) |=> evt_q[0])
      else $error("flag one dropped by itself");
   a_flag_sticky_two: assert property (@(posedge sys_clk) disable iff (!nrst)
      (evt_q[1] && !wr_ctrl[1]) |=> evt_q[1])
      else $error("flag two dropped by itself");
   // A written zero clears; an event in the same cycle wins so none is lost
   a_flag_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
      (wr_ctrl[0] && !hwdata[CTL_EVT] && !hit[0]) |=> !evt_q[0])
      else $error("flag clear ignored");
   a_set_wins: assert property (@(posedge sys_clk) disable iff (!nrst)
      (wr_ctrl[0] && hit[0]) |=> evt_q[0])
      else $error("clear beat a new event");

   // Code 00 stays silent on both channels
   a_none_quiet: assert property (@(posedge sys_clk) disable iff (!nrst)
      (ctrl_q[0][CTL_EDGE_HI:CTL_EDGE_LO] == 2'b00) |-> !hit[0])
      else $error("event with selection off");
   a_none_quiet_two: assert property (@(posedge sys_clk) disable iff (!nrst)
      (ctrl_q[1][CTL_EDGE_HI:CTL_EDGE_LO] == 2'b00) |-> !hit[1])
      else $error("event two with selection off");
   // Code 11: any change counts; stable setup keeps enable edges out of the check
   a_any_change: assert property (@(posedge sys_clk) disable iff (!nrst)
      (ctrl_q[0][CTL_EDGE_HI:CTL_EDGE_LO] == 2'b11 && active[0] && !evt_q[0]
       && $changed(adj[0]) && $stable(active[0]) && $stable(ctrl_q[0])) |=> evt_q[0])
      else $error("any change missed");
   a_any_change_two: assert property (@(posedge sys_clk) disable iff (!nrst)
      (ctrl_q[1][CTL_EDGE_HI:CTL_EDGE_LO] == 2'b11 && active[1] && !evt_q[1]
       && $changed(adj[1]) && $stable(active[1]) && $stable(ctrl_q[1])) |=> evt_q[1])
      else $error("any change two missed");
   // Codes 01 and 10 pick their edge by polarity
   a_rise_code: assert property (@(posedge sys_clk) disable iff (!nrst)
      (ctrl_q[0][CTL_EDGE_HI:CTL_EDGE_LO] == 2'b01 && !ctrl_q[0][CTL_INV] && hit[0]) |-> adj[0])
      else $error("rising code wrong edge");
   a_rise_inverted: assert property (@(posedge sys_clk) disable iff (!nrst)
      (ctrl_q[0][CTL_EDGE_HI:CTL_EDGE_LO] == 2'b01 && ctrl_q[0][CTL_INV] && hit[0]) |-> !adj[0])
      else $error("inverted rising code wrong edge");
   a_fall_code: assert property (@(posedge sys_clk) disable iff (!nrst)
      (ctrl_q[0][CTL_EDGE_HI:CTL_EDGE_LO] == 2'b10 && !ctrl_q[0][CTL_INV] && hit[0]) |-> !adj[0])
      else $error("falling code wrong edge");
   a_fall_inverted: assert property (@(posedge sys_clk) disable iff (!nrst)
      (ctrl_q[0][CTL_EDGE_HI:CTL_EDGE_LO] == 2'b10 && ctrl_q[0][CTL_INV] && hit[0]) |-> adj[0])
      else $error("inverted falling code wrong edge");

   // Disabled channel: core parked, pin released, no events
   a_off_silent: assert property (@(posedge sys_clk) disable iff (!nrst)
      !ctrl_q[0][CTL_ON] |-> (!analog_ctl[0].enable && !result_pin_oe[0] && !hit[0]))
      else $error("disabled channel active");
   a_off_silent_two: assert property (@(posedge sys_clk) disable iff (!nrst)
      !ctrl_q[1][CTL_ON] |-> (!analog_ctl[1].enable && !result_pin_oe[1] && !hit[1]))
      else $error("disabled channel two active");
   // Stop in idle parks all channels; otherwise the enable bits alone rule
   a_idle_stop: assert property (@(posedge sys_clk) disable iff (!nrst)
      (idle_q && cpu_idle) |-> (active == 2'b00))
      else $error("idle stop ignored");
   a_idle_run: assert property (@(posedge sys_clk) disable iff (!nrst)
      !(idle_q && cpu_idle) |-> (active == {ctrl_q[1][CTL_ON], ctrl_q[0][CTL_ON]}))
      else $error("running channel held off");

   // Core setup follows the control bits of its own channel
   a_low_power: assert property (@(posedge sys_clk) disable iff (!nrst)
      (analog_ctl[0].low_power == ctrl_q[0][CTL_LP]) && (analog_ctl[1].low_power == ctrl_q[1][CTL_LP]))
      else $error("low power select lost");
   a_noninv_route: assert property (@(posedge sys_clk) disable iff (!nrst)
      (analog_ctl[0].noninv_sel == ctrl_q[0][CTL_NONINV]) && (analog_ctl[1].noninv_sel == ctrl_q[1][CTL_NONINV]))
      else $error("noninverting source wrong");
   a_inv_route: assert property (@(posedge sys_clk) disable iff (!nrst)
      analog_ctl[0].inv_sel == ctrl_q[0][CTL_INVSEL_HI:CTL_INVSEL_LO])
      else $error("inverting source wrong");
   // Adjusted result and its status copies; a parked channel reads low
   a_result_adjust: assert property (@(posedge sys_clk) disable iff (!nrst)
      adj[0] == (active[0] & (clean_q[0] ^ ctrl_q[0][CTL_INV])))
      else $error("adjusted result wrong");
   a_status_mirror: assert property (@(posedge sys_clk) disable iff (!nrst)
      (stat_word[ST_EVT2] == evt_q[1]) && (stat_word[ST_RES1] == adj[0]))
      else $error("status mirror mismatch");
   a_status_mirror_two: assert property (@(posedge sys_clk) disable iff (!nrst)
      (stat_word[ST_EVT1] == evt_q[0]) && (stat_word[ST_RES2] == adj[1]))
      else $error("status mirror two mismatch");

   // Filter moves only when stages two and three agree, so a one-cycle glitch never lands
   a_sync_agree: assert property (@(posedge sys_clk) disable iff (!nrst)
      (sync_q[0][2] == sync_q[0][1]) |=> (clean_q[0] == $past(sync_q[0][2])))
      else $error("filtered level wrong");
   a_sync_hold: assert property (@(posedge sys_clk) disable iff (!nrst)
      (sync_q[0][2] != sync_q[0][1]) |=> (clean_q[0] == $past(clean_q[0])))
      else $error("filtered level moved early");
   a_sync_agree_two: assert property (@(posedge sys_clk) disable iff (!nrst)
      (sync_q[1][2] == sync_q[1][1]) |=> (clean_q[1] == $past(sync_q[1][2])))
      else $error("filtered level two wrong");
   // Pin carries the raw result, so it may lead the flag by a few cycles
   a_pin_polarity: assert property (@(posedge sys_clk) disable iff (!nrst)
      active[1] |-> (result_pin[1] == (raw_result[1] ^ ctrl_q[1][CTL_INV])))
      else $error("pin polarity wrong");
   a_pin_polarity_one: assert property (@(posedge sys_clk) disable iff (!nrst)
      active[0] |-> (result_pin[0] == (raw_result[0] ^ ctrl_q[0][CTL_INV])))
      else $error("pin one polarity wrong");
   a_pin_drive: assert property (@(posedge sys_clk) disable iff (!nrst)
      !ctrl_q[1][CTL_OE] |-> !result_pin_oe[1])
      else $error("pin driven while drive off");
   a_pin_drive_one: assert property (@(posedge sys_clk) disable iff (!nrst)
      !ctrl_q[0][CTL_OE] |-> !result_pin_oe[0])
      else $error("pin one driven while drive off");

   // Interrupt: an event raises the sticky bit, and the line if it is unmasked
   a_irq_follows: assert property (@(posedge sys_clk) disable iff (!nrst)
      (hit[0] && imask_q[0] && !(wr_pend_q && wr_addr_q == OFF_IRQ_MASK)) |=> irq)
      else $error("interrupt line missed");
   a_ist_sets: assert property (@(posedge sys_clk) disable iff (!nrst)
      hit[1] |=> ist_q[1])
      else $error("interrupt status two missed");
   a_ist_sets_one: assert property (@(posedge sys_clk) disable iff (!nrst)
      hit[0] |=> ist_q[0])
      else $error("interrupt status one missed");
   // Bus: zero wait, always OKAY, upper half reads zero, writes land masked
   a_bus_okay: assert property (@(posedge sys_clk) disable iff (!nrst)
      hreadyout && !hresp)
      else $error("bus answer not okay");
   a_upper_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
      hrdata[31:16] == 16'h0000)
      else $error("upper read half not zero");
   a_write_lands: assert property (@(posedge sys_clk) disable iff (!nrst)
      wr_ctrl[0] |=> (ctrl_q[0] == ($past(hwdata[15:0]) & CTRL_WMASK)))
      else $error("control write lost");

   // Main scenarios: events on each channel, interrupt, idle stop, flag clear
   c_event_ch1: cover property (@(posedge sys_clk) disable iff (!nrst) hit[0]);
   c_event_ch2: cover property (@(posedge sys_clk) disable iff (!nrst) hit[1]);
   c_irq: cover property (@(posedge sys_clk) disable iff (!nrst) irq);
   c_idle: cover property (@(posedge sys_clk) disable iff (!nrst) idle_q && cpu_idle);
   c_flag_cleared: cover property (@(posedge sys_clk) disable iff (!nrst)
      wr_ctrl[0] && evt_q[0] && !hwdata[CTL_EVT]);
endmodule : dual_comparator_control
`default_nettype wire

// File: analog_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module analog_core_model (
   // Clock
   input wire logic sys_clk,
   // Core settings and input voltages: A, ref, B, C, D, half bandgap
   input wire cmp_pkg::analog_ctl_t analog_ctl [2],
   input var int volt [2][6],
   // Raw results
   output logic [1:0] raw_result
);
   import cmp_pkg::*;
   logic flip_q = 1'h0;
   // A parked core has no defined level, so it toggles to expose any reliance on it
   always_ff @(posedge sys_clk) flip_q <= ~flip_q;
   // Pick both inputs through the muxes, then compare
   always_comb begin
      for (int c = 0; c < 2; c++) begin
         raw_result[c] = flip_q;
         if (analog_ctl[c].enable)
            raw_result[c] = volt[c][analog_ctl[c].noninv_sel] >
               volt[c][2 + analog_ctl[c].inv_sel];
      end
   end
endmodule : analog_core_model
`default_nettype wire

// File: dual_comparator_control_test.sv
`timescale 1ns/1ps
`default_nettype none
module dual_comparator_control_test;
   import cmp_pkg::*;
   logic sys_clk = 1'h0;
   logic nrst = 1'h0;
   logic [11:0] haddr = 12'h000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'h0;
   logic [31:0] hwdata = 32'h0;
   logic cpu_idle = 1'h0;
   logic [31:0] hrdata, rd;
   logic hreadyout, hresp, irq;
   logic [1:0] raw_result, result_pin, result_pin_oe;
   analog_ctl_t analog_ctl [2];
   int volt [2][6];
   int fails = 0;
   int checked = 0;
   int seed = 32'hdb19;
   // 100 MHz system clock
   always #5 sys_clk = ~sys_clk;
   dual_comparator_control u_dual_comparator_control (.sys_clk(sys_clk), .nrst(nrst),
      .hsel(1'h1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .cpu_idle(cpu_idle), .raw_result(raw_result), .analog_ctl(analog_ctl),
      .result_pin(result_pin), .result_pin_oe(result_pin_oe), .irq(irq));
   analog_core_model u_analog_core_model (.sys_clk(sys_clk), .analog_ctl(analog_ctl),
      .volt(volt), .raw_result(raw_result));
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk
   // One transfer: address phase, then data phase, each held until hready is seen
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      hwrite <= wr;
      haddr <= a;
      htrans <= 2'h2;
      @(posedge sys_clk);
      while (hreadyout !== 1'h1) @(posedge sys_clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge sys_clk);
      while (hreadyout !== 1'h1) @(posedge sys_clk);
      rd = hrdata;
      chk("hresp", {31'h0, hresp}, 32'h0);
   endtask : bus
   // Long enough for synchronizer, filter, flag and interrupt to land
   task automatic settle;
      repeat (8) @(posedge sys_clk);
   endtask : settle
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   // Watchdog: the whole sequence needs well under a tenth of this
   initial begin
      #200000;
      fails++;
      tally_and_finish;
   end
   initial begin
      repeat (8) @(posedge sys_clk);
      nrst <= 1'h1;
      @(posedge sys_clk);
      // All registers and one unmapped word read zero after reset
      for (int a = 0; a <= 20; a += 4) begin
         bus(0, a[11:0], 0);
         chk("reset value", rd, 32'h0);
      end
      // Every mux setting on both channels, random voltages and polarity
      for (int m = 0; m < 16; m++) begin
         int c, s, inv, lp, e;
         logic [15:0] ctl;
         c = m >> 3;
         s = m & 7;
         for (int k = 0; k < 6; k++) volt[c][k] <= $random(seed) & 32'hFF;
         inv = $random(seed) & 1;
         lp = $random(seed) & 1;
         ctl = 16'hC000 | (inv << 13) | (lp << 12) | ((s >> 2) << 4) | (s & 3);
         bus(1, OFF_CTRL1 + 12'(4 * c), {16'h0, ctl});
         settle;
         e = (volt[c][s >> 2] > volt[c][2 + (s & 3)]) ^ inv;
         bus(0, OFF_CTRL1 + 12'(4 * c), 0);
         chk("control", rd, {16'h0, ctl} | (e << 8));
         bus(0, OFF_STAT, 0);
         chk("status result", rd[c], e);
         chk("pin", result_pin[c], e);
         chk("pin enable", result_pin_oe[c], 1);
         chk("core setup", analog_ctl[c], {1'h1, lp[0], s[2:0]});
      end
      // Writable bits land, read-only ones ignore the write, a one sets the flag
      bus(1, OFF_CTRL2, 32'hFFFF_FFFF);
      settle;
      bus(0, OFF_CTRL2, 0);
      chk("control write", rd, 32'hF2D3 | ((volt[1][1] <= volt[1][5]) << 8));
      // Each event code and polarity: rise, then fall while the flag still stands
      for (int m = 0; m < 8; m++) begin
         int code, inv, e1, e2;
         code = m >> 1;
         inv = m & 1;
         volt[0][0] <= inv ? 5 : 1;
         volt[0][2] <= 3;
         bus(1, OFF_CTRL1, 16'h8000 | (inv << 13) | (code << 6));
         settle;
         bus(1, OFF_CTRL1, 16'h8000 | (inv << 13) | (code << 6));
         bus(1, OFF_IRQ_STAT, 32'h3);
         bus(1, OFF_IRQ_MASK, 32'h1);
         volt[0][0] <= inv ? 1 : 5;
         settle;
         e1 = code == 3 || (code == 1 && !inv) || (code == 2 && inv);
         bus(0, OFF_IRQ_STAT, 0);
         chk("event on rise", rd, e1);
         chk("irq on rise", irq, e1);
         bus(1, OFF_IRQ_STAT, 32'h1);
         volt[0][0] <= inv ? 5 : 1;
         settle;
         e2 = !e1 && (code == 3 || (code == 1 && inv) || (code == 2 && !inv));
         bus(0, OFF_IRQ_STAT, 0);
         chk("event on fall", rd, e2);
         bus(1, OFF_IRQ_MASK, 32'h0);
         bus(0, OFF_STAT, 0);
         chk("flag mirror", rd[8], e1 | e2);
         chk("masked irq", irq, 0);
      end
      // Idle with the stop bit set parks every channel
      bus(1, OFF_CTRL1, 32'hC000);
      bus(1, OFF_STAT, 32'h8000);
      cpu_idle <= 1'h1;
      settle;
      chk("idle pin enable", result_pin_oe, 2'h0);
      bus(0, OFF_STAT, 0);
      chk("idle status", rd & 32'h8003, 32'h8000);
      cpu_idle <= 1'h0;
      settle;
      chk("run pin enable", result_pin_oe[0], 1);
      bus(1, OFF_CTRL1, 32'h4000);
      bus(0, OFF_CTRL1, 0);
      chk("off control", rd, 32'h4000);
      chk("off pin enable", result_pin_oe[0], 0);
      tally_and_finish;
   end
endmodule : dual_comparator_control_test
`default_nettype wire
